// ==== power_resource_pkg.sv ====
package power_resource_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PAD_PULL   = 8'h1c;
    localparam logic [7:0] IDX_REFERENCE  = 8'h1d;
    localparam logic [7:0] IDX_BACKUP_REG = 8'h1e;
    localparam logic [7:0] IDX_IO_CONV    = 8'h20;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // pad pull control field positions
    localparam int PP_CTL_BUS_BIT   = 6;
    localparam int PP_SCALE_BUS_BIT = 5;
    localparam int PP_PWR_REQ_BIT   = 4;
    localparam int PP_SLEEP_BIT     = 3;
    localparam int PP_HOLD_BIT      = 2;
    localparam int PP_COLD_RST_BIT  = 1;
    localparam int PP_RST_OUT_BIT   = 0;
    localparam logic [7:0] PP_WR_MASK = 8'h7f;
    localparam logic [7:0] PP_RESET   = 8'h1f;

    // reference and backup regulator state fields
    localparam int ST_LSB = 0;
    localparam logic [1:0] REF_ST_RESET    = 2'h1;
    localparam logic [1:0] BACKUP_ST_RESET = 2'h1;
    localparam int BACKUP_MASK_BIT = 3;

    // io converter fields
    localparam int IO_ILIM_LSB = 6;
    localparam int IO_SEL_LSB  = 2;
    localparam logic [1:0] IO_ILIM_RESET = 2'h0;
    localparam logic [1:0] IO_ST_RESET   = 2'h0;

    // supply state encodings
    localparam logic [1:0] ST_OFF        = 2'h0;
    localparam logic [1:0] ST_ACTIVE     = 2'h1;
    localparam logic [1:0] ST_OFF_ALT    = 2'h2;
    localparam logic [1:0] ST_SLEEP      = 2'h3;

    // current limit encodings
    localparam logic [1:0] ILIM_0A6 = 2'h0;
    localparam logic [1:0] ILIM_1A0 = 2'h1;

    // voltage select encodings
    localparam logic [1:0] VSEL_1V5 = 2'h0;
    localparam logic [1:0] VSEL_1V8 = 2'h1;
    localparam logic [1:0] VSEL_2V5 = 2'h2;
    localparam logic [1:0] VSEL_3V3 = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        LIM_0A6 = 2'h0,
        LIM_1A0 = 2'h1,
        LIM_1A3 = 2'h2
    } current_limit_t;

    typedef struct packed {
        logic ctl_bus_pullup_en;
        logic scaling_bus_pullup_en;
        logic power_request_pullup_en;
        logic sleep_pad_pulldown_en;
        logic hold_pad_pulldown_en;
        logic cold_reset_pulldown_en;
        logic second_reset_out_pulldown_en;
    } pad_pull_t;

    typedef struct packed {
        logic [1:0]     current_limit_sel;
        current_limit_t current_limit;
        logic [1:0]     voltage_sel;
        logic [1:0]     supply_state;
        logic           enabled;
        logic           low_power;
    } io_conv_t;

    typedef struct packed {
        logic       full_load;
        logic       low_power;
        logic [1:0] state;
    } backup_reg_t;

endpackage

// ==== power_resource_control_regs.sv ====
// The AXI4-Lite interface to the registers was left to the implementer.
module power_resource_control_regs
    import power_resource_pkg::*;
(
    // clock and resets
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              turnoff_reset,
    // device condition and boot configuration
    input  wire logic              test_mode,
    input  wire logic              device_off,
    input  wire logic              device_backup,
    input  wire logic [1:0]        boot_io_voltage_sel,
    input  wire logic              boot_backup_full_load,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // pad and regulator controls
    output pad_pull_t              pad_pull,
    output logic [1:0]             reference_state,
    output backup_reg_t            backup_regulator,
    output io_conv_t               io_converter
);

    // byte address of a register index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        logic [9:0] full;
        full = {idx, 2'b00};
        return full[ADDR_W-1:0];
    endfunction

    // decode an address into a one-hot register select
    function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
        logic [3:0] sel;
        sel = 4'h0;
        if (a == byte_addr(IDX_PAD_PULL)) begin
            sel = 4'h1;
        end else if (a == byte_addr(IDX_REFERENCE)) begin
            sel = 4'h2;
        end else if (a == byte_addr(IDX_BACKUP_REG)) begin
            sel = 4'h4;
        end else if (a == byte_addr(IDX_IO_CONV)) begin
            sel = 4'h8;
        end
        return sel;
    endfunction

    // register storage
    logic [7:0]        pad_pull_r;
    logic [1:0]        ref_st_r;
    logic              backup_mask_r;
    logic [1:0]        backup_st_r;
    logic [1:0]        io_ilim_r;
    logic [1:0]        io_sel_r;
    logic [1:0]        io_st_r;

    // bus state
    logic              aw_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic              w_held_r;
    logic [7:0]        w_data_r;
    logic              w_lane0_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [DATA_W-1:0] rdata_r;

    wire               general_rst = reset;
    // turn-off reset domain includes general reset
    wire               turnoff_rst = reset | turnoff_reset;

    // write channel handshakes
    wire               aw_take  = s_axi_awvalid & s_axi_awready;
    wire               w_take   = s_axi_wvalid & s_axi_wready;
    wire               aw_have  = aw_held_r | aw_take;
    wire               w_have   = w_held_r | w_take;
    wire               wr_fire  = aw_have & w_have & ~bvalid_r;
    wire [ADDR_W-1:0]  wr_addr  = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [7:0]         wr_byte  = w_held_r ? w_data_r : s_axi_wdata[7:0];
    wire               wr_lane0 = w_held_r ? w_lane0_r : s_axi_wstrb[0];
    wire [3:0]         wr_sel   = decode(wr_addr);
    wire               wr_en    = wr_fire & wr_lane0;
    wire               wr_pad   = wr_en & wr_sel[0];
    wire               wr_ref   = wr_en & wr_sel[1];
    wire               wr_bak   = wr_en & wr_sel[2];
    wire               wr_io    = wr_en & wr_sel[3];

    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready  = ~w_held_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // read channel
    wire               rd_take = s_axi_arvalid & s_axi_arready;
    wire [3:0]         rd_sel  = decode(s_axi_araddr);
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    wire [7:0]         rd_pad = pad_pull_r & PP_WR_MASK;
    wire [7:0]         rd_ref = {6'h00, ref_st_r};
    wire [7:0]         rd_bak = {4'h0, backup_mask_r, 1'b0, backup_st_r};
    wire [7:0]         rd_io  = {io_ilim_r, 2'b00, io_sel_r, io_st_r};
    wire [7:0]         rd_byte = rd_sel[0] ? rd_pad :
                                 rd_sel[1] ? rd_ref :
                                 rd_sel[2] ? rd_bak :
                                 rd_sel[3] ? rd_io  : 8'h00;

    // write address and data holding
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r  <= 1'b0;
            w_data_r  <= 8'h00;
            w_lane0_r <= 1'b0;
        end else begin
            aw_held_r <= aw_have & ~wr_fire;
            w_held_r  <= w_have & ~wr_fire;
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_r  <= s_axi_wdata[7:0];
                w_lane0_r <= s_axi_wstrb[0];
            end
        end
    end

    // write response; unmapped address answers slverr
    always_ff @(posedge clk) begin
        if (reset) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wr_sel == 4'h0) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // read response one cycle after address
    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= '0;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rresp_r  <= (rd_sel == 4'h0) ? RESP_SLVERR : RESP_OKAY;
            rdata_r  <= {24'h000000, rd_byte};
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // pad pull register, general reset domain
    always_ff @(posedge clk) begin
        if (general_rst) begin
            pad_pull_r <= PP_RESET;
        end else if (wr_pad) begin
            pad_pull_r <= wr_byte & PP_WR_MASK;
        end
    end

    // reference state, test mode writes only
    always_ff @(posedge clk) begin
        if (turnoff_rst) begin
            ref_st_r <= REF_ST_RESET;
        end else if (wr_ref & test_mode) begin
            ref_st_r <= wr_byte[ST_LSB +: 2];
        end
    end

    // backup mask, boot default, general reset domain
    always_ff @(posedge clk) begin
        if (general_rst) begin
            backup_mask_r <= boot_backup_full_load;
            backup_st_r   <= BACKUP_ST_RESET;
        end else if (wr_bak) begin
            backup_mask_r <= wr_byte[BACKUP_MASK_BIT];
            // state field held unless test mode
            if (test_mode) begin
                backup_st_r <= wr_byte[ST_LSB +: 2];
            end
        end
    end

    // io converter register, turn-off reset domain
    always_ff @(posedge clk) begin
        if (turnoff_rst) begin
            io_ilim_r <= IO_ILIM_RESET;
            io_sel_r  <= boot_io_voltage_sel;
            io_st_r   <= IO_ST_RESET;
        end else if (wr_io) begin
            io_ilim_r <= wr_byte[IO_ILIM_LSB +: 2];
            io_sel_r  <= wr_byte[IO_SEL_LSB +: 2];
            io_st_r   <= wr_byte[ST_LSB +: 2];
        end
    end

    // pad control outputs
    // control bus pullups
    assign pad_pull.ctl_bus_pullup_en            = pad_pull_r[PP_CTL_BUS_BIT];
    assign pad_pull.scaling_bus_pullup_en        = pad_pull_r[PP_SCALE_BUS_BIT];
    assign pad_pull.power_request_pullup_en      = pad_pull_r[PP_PWR_REQ_BIT];
    assign pad_pull.sleep_pad_pulldown_en        = pad_pull_r[PP_SLEEP_BIT];
    assign pad_pull.hold_pad_pulldown_en         = pad_pull_r[PP_HOLD_BIT];
    assign pad_pull.cold_reset_pulldown_en       = pad_pull_r[PP_COLD_RST_BIT];
    assign pad_pull.second_reset_out_pulldown_en = pad_pull_r[PP_RST_OUT_BIT];

    assign reference_state = ref_st_r;

    // backup regulator mode
    // backup forces low power
    wire bak_low = device_backup | (device_off & ~backup_mask_r);
    assign backup_regulator.low_power = bak_low;
    assign backup_regulator.full_load = ~bak_low;
    assign backup_regulator.state     = backup_st_r;

    // io converter decoded controls
    // current limit decode
    assign io_converter.current_limit_sel = io_ilim_r;
    assign io_converter.current_limit     = (io_ilim_r == ILIM_0A6) ? LIM_0A6 :
                                            (io_ilim_r == ILIM_1A0) ? LIM_1A0 : LIM_1A3;
    assign io_converter.voltage_sel       = io_sel_r;
    assign io_converter.supply_state      = io_st_r;
    // on for active or sleep codes
    assign io_converter.enabled           = (io_st_r == ST_ACTIVE) | (io_st_r == ST_SLEEP);
    assign io_converter.low_power         = (io_st_r == ST_SLEEP);

endmodule

// ==== power_resource_control_regs_chk.sv ====
module power_resource_control_regs_chk
    import power_resource_pkg::*;
(
    // clock and resets
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              turnoff_reset,
    // device condition
    input wire logic              test_mode,
    input wire logic              device_off,
    input wire logic              device_backup,
    // write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    // controls
    input wire pad_pull_t         pad_pull,
    input wire logic [1:0]        reference_state,
    input wire backup_reg_t       backup_regulator,
    input wire io_conv_t          io_converter
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] aw_q;
    logic [7:0] wd_q;
    logic       ws_q;
    // last accepted write address and data
    always_ff @(posedge clk) begin
        if (s_axi_awvalid && s_axi_awready)
            aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) begin
            wd_q <= s_axi_wdata[7:0];
            ws_q <= s_axi_wstrb[0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_wr(logic [7:0] a);
        $rose(s_axi_bvalid) && aw_q == a && ws_q;
    endsequence
    property p_pad_bus; s_wr(8'h70) |-> {pad_pull.ctl_bus_pullup_en,
        pad_pull.scaling_bus_pullup_en} == wd_q[6:5]; endproperty
    a_pad_bus: assert property (p_pad_bus) else $error("bus pullups differ");
    property p_pad_low; s_wr(8'h70) |-> pad_pull[4:0] == wd_q[4:0]; endproperty
    a_pad_low: assert property (p_pad_low) else $error("pad pulls differ");
    property p_pad_rst; $fell(reset) |-> pad_pull == 7'h1f; endproperty
    a_pad_rst: assert property (p_pad_rst) else $error("pad reset value");
    property p_toff; turnoff_reset |=> reference_state == 2'h1 && io_converter.supply_state == 2'h0;
    endproperty
    a_toff: assert property (p_toff) else $error("turn-off reset value");
    property p_ref_ro; $rose(s_axi_bvalid) && !$past(test_mode) |-> $stable(reference_state);
    endproperty
    a_ref_ro: assert property (p_ref_ro) else $error("reference state written");
    property p_bk_mask; s_wr(8'h78) ##0 (device_off && !device_backup)
        |-> backup_regulator.full_load == wd_q[3]; endproperty
    a_bk_mask: assert property (p_bk_mask) else $error("off mask ignored");
    property p_bk_bkp; device_backup |-> backup_regulator.low_power && !backup_regulator.full_load;
    endproperty
    a_bk_bkp: assert property (p_bk_bkp) else $error("backup not low power");
    property p_io_lim; io_converter.current_limit == (io_converter.current_limit_sel[1] ? LIM_1A3
        : io_converter.current_limit_sel[0] ? LIM_1A0 : LIM_0A6); endproperty
    a_io_lim: assert property (p_io_lim) else $error("current limit decode");
    property p_io_wr; s_wr(8'h80) |-> {io_converter.voltage_sel, io_converter.supply_state}
        == wd_q[3:0]; endproperty
    a_io_wr: assert property (p_io_wr) else $error("io fields differ");
    // main scenarios
    c_io: cover property (s_wr(8'h80));
    c_test: cover property ($rose(s_axi_bvalid) && test_mode);
    c_bkp: cover property (device_backup && device_off);
endmodule

bind power_resource_control_regs power_resource_control_regs_chk u_chk (.clk(clk), .reset(reset),
    .turnoff_reset(turnoff_reset), .test_mode(test_mode), .device_off(device_off),
    .device_backup(device_backup), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .pad_pull(pad_pull), .reference_state(reference_state),
    .backup_regulator(backup_regulator), .io_converter(io_converter));

// ==== power_resource_control_regs_test.sv ====
module power_resource_control_regs_test
    import power_resource_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, reset, turnoff_reset, test_mode, device_off, device_backup, boot_fl;
    logic [1:0] boot_sel, bresp, rresp;
    logic [7:0] awaddr, araddr, v;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    pad_pull_t pad_pull;
    logic [1:0] reference_state;
    backup_reg_t backup_regulator;
    io_conv_t io_converter;
    int fails, n_checks, i;
    power_resource_control_regs u_dut (.clk(clk), .reset(reset), .turnoff_reset(turnoff_reset),
        .test_mode(test_mode), .device_off(device_off), .device_backup(device_backup),
        .boot_io_voltage_sel(boot_sel), .boot_backup_full_load(boot_fl),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pad_pull(pad_pull), .reference_state(reference_state),
        .backup_regulator(backup_regulator), .io_converter(io_converter));
    // 50 ns clock
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one write: address and data together, bready held until the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask
    // one read
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
    endtask
    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        results();
    end
    // test sequence
    initial begin
        {reset, turnoff_reset, test_mode, device_off, device_backup, boot_fl} <= 6'h21;
        boot_sel <= 2'h2;
        {awaddr, araddr, wdata, wstrb} <= 52'h0;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rd(8'h70, 32'h1f, RESP_OKAY);
        rd(8'h74, 32'h01, RESP_OKAY);
        rd(8'h78, 32'h09, RESP_OKAY);
        rd(8'h80, 32'h08, RESP_OKAY);
        $display("reset values done");
        for (i = 0; i < 7; i++) begin
            v = 8'(32'h00050a10 >> (8 * (i % 4))) | 8'(i == 4 ? 8'hff : i == 5 ? 8'h40 : 8'h20);
            wr(8'h70, 32'(v), 4'hf, RESP_OKAY);
            rd(8'h70, 32'(v & 8'h7f), RESP_OKAY);
            chk(32'(pad_pull), 32'(v[6:0]));
        end
        $display("pad pull done");
        wr(8'h74, 32'hff, 4'hf, RESP_OKAY);
        rd(8'h74, 32'h01, RESP_OKAY);
        wr(8'h78, 32'hff, 4'hf, RESP_OKAY);
        rd(8'h78, 32'h09, RESP_OKAY);
        device_off <= 1'b1;
        wr(8'h78, 32'h00, 4'hf, RESP_OKAY);
        chk(32'(backup_regulator.low_power), 32'h1);
        wr(8'h78, 32'h08, 4'hf, RESP_OKAY);
        chk(32'(backup_regulator.full_load), 32'h1);
        device_backup <= 1'b1;
        test_mode <= 1'b1;
        @(posedge clk);
        chk(32'(backup_regulator.low_power), 32'h1);
        chk(32'(backup_regulator.full_load), 32'h0);
        wr(8'h78, 32'h0f, 4'hf, RESP_OKAY);
        rd(8'h78, 32'h0b, RESP_OKAY);
        chk(32'(backup_regulator.state), 32'h3);
        wr(8'h74, 32'hfe, 4'hf, RESP_OKAY);
        rd(8'h74, 32'h02, RESP_OKAY);
        chk(32'(reference_state), 32'h2);
        {test_mode, device_off, device_backup} <= 3'h0;
        $display("reference and backup done");
        for (i = 0; i < 4; i++) begin
            v = {i[1:0], 2'h3, i[1:0], i[1:0]};
            wr(8'h80, 32'(v), 4'hf, RESP_OKAY);
            rd(8'h80, 32'(v & 8'hcf), RESP_OKAY);
            chk(32'(io_converter.current_limit), (i > 1) ? 32'h2 : 32'(i));
            chk(32'(io_converter.enabled), 32'(i % 2));
            chk(32'(io_converter.low_power), 32'(i == 3));
            chk(32'(io_converter.voltage_sel), 32'(i));
        end
        $display("io converter done");
        boot_sel <= 2'h1;
        turnoff_reset <= 1'b1;
        repeat (2) @(posedge clk);
        turnoff_reset <= 1'b0;
        rd(8'h74, 32'h01, RESP_OKAY);
        rd(8'h80, 32'h04, RESP_OKAY);
        rd(8'h78, 32'h0b, RESP_OKAY);
        rd(8'h70, 32'h25, RESP_OKAY);
        wr(8'h7c, 32'hff, 4'hf, RESP_SLVERR);
        rd(8'h7c, 32'h00, RESP_SLVERR);
        wr(8'h70, 32'hff, 4'h0, RESP_OKAY);
        rd(8'h70, 32'h25, RESP_OKAY);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(8'h70, 32'h1f, RESP_OKAY);
        rd(8'h78, 32'h09, RESP_OKAY);
        $display("turn-off, unmapped and reset done");
        results();
    end
endmodule
